// *** design/otp_usb_config_lock_bank.sv ***
// OTP configuration bank with lock bytes, reached over AXI4-Lite
// Function
// [RULE_01] With wake-advertise-valid set, descriptor bit D5 carries the remote-wakeup-enable bit.
// [RULE_02] With wake-advertise-valid clear, D5 does not advertise the wakeup setting.
// [RULE_03] Power mode 00 reports bus powered, 01 and 10 self powered, 11 is invalid.
// [RULE_04] Receive FIFO is flushed on port close if bit 4 is set and on open if bit 3 is set.
// [RULE_05] Transmit FIFO is flushed on port close if bit 2 is set and on open if bit 1 is set.
// [RULE_06] A field whose lock bit is set counts as programmed and takes no more writes.
// [RULE_07] A field's stored OTP value is used only while its lock bit is one.
// [RULE_08] Low lock byte: bit 7 language, bits 6 to 3 serial pins three to zero, bit 2 serial text.
// [RULE_09] High lock byte: maker text b, maker text a, flush, release, attributes, power, product, maker.
// [RULE_10] Software enters a field completely before locking it, or the rest burns as zeros.
// [RULE_11] Select codes 000 to 100 drive one during their condition and zero otherwise.
// [RULE_12] Select codes 101, 110, 111 drive zero during suspend, low power, bus reset, else one.
// [RULE_13] Drive code 01 gives open drain, 10 push-pull; 00 and 11 are not to be used.
// [RULE_14] Software writes zero to every reserved bit.
// [RULE_15] An unlocked field uses the built-in default instead of OTP contents.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module otp_usb_config_lock_bank (
   input  wire logic                       clock,
   input  wire logic                       rstn,
   input  wire logic [otp_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [otp_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       port_opened,
   input  wire logic                       port_closed,
   input  wire otp_cfg_pkg::usb_state_s    usb_state,
   output logic [7:0]                      desc_bm_attributes,
   output logic                            power_mode_invalid,
   output logic [7:0]                      release_major,
   output logic [7:0]                      release_minor,
   output logic [7:0]                      field_lock_lo,
   output logic [7:0]                      field_lock_hi,
   output logic                            rx_fifo_flush,
   output logic                            tx_fifo_flush,
   output logic                            suspend_indicator_pin,
   output logic                            suspend_indicator_pin_oe
);
   import otp_cfg_pkg::*;

   logic              aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic              w_held;
   logic [7:0]        w_byte;
   logic              w_lane0;
   logic              do_write;
   logic [7:0]        widx;
   logic [7:0]        ridx;
   logic              w_ok;
   logic              w_refused;
   usb_attr_s         stage_attr;
   logic [7:0]        stage_major;
   logic [7:0]        stage_minor;
   logic [7:0]        stage_flush;
   stat_cfg_s         stat_cfg;
   logic [7:0]        lock_lo;
   logic [7:0]        lock_hi;
   logic [7:0]        next_lock_hi;
   usb_attr_s         otp_attr;
   logic [7:0]        otp_major;
   logic [7:0]        otp_minor;
   logic [7:0]        otp_flush;
   usb_attr_s         eff_attr;
   logic [7:0]        eff_flush;
   logic [7:0]        rd_val;
   logic              rd_hit;

   // Write path: address and data taken in either order
   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign widx     = {2'h0, aw_addr[ADDR_W-1:2]};
   assign w_ok     = (aw_addr[1:0] == 2'h0) &&
                     (widx == IDX_ATTR || widx == IDX_MAJOR || widx == IDX_MINOR || widx == IDX_FLUSH ||
                      widx == IDX_LOCK_LO || widx == IDX_LOCK_HI || widx == IDX_STAT);
   assign w_refused = (widx == IDX_ATTR && lock_hi[LK_ATTR]) ||
                      ((widx == IDX_MAJOR || widx == IDX_MINOR) && lock_hi[LK_RELEASE]) ||
                      (widx == IDX_FLUSH && lock_hi[LK_FLUSH]); // [RULE_06]

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_held      <= 1'b0;
         aw_addr      <= '0;
         w_held       <= 1'b0;
         w_byte       <= RST_REG;
         w_lane0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         // Readies are registered copies of the next idle state
         s_axi_awready <= ~do_write & ~(aw_held | (s_axi_awvalid & s_axi_awready)) &
                          ~(s_axi_bvalid & ~s_axi_bready);
         s_axi_wready  <= ~do_write & ~(w_held | (s_axi_wvalid & s_axi_wready)) &
                          ~(s_axi_bvalid & ~s_axi_bready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (w_ok && !(w_lane0 && w_refused)) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Staged field values; locked fields refuse writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stage_attr  <= RST_REG;
         stage_major <= RST_REG;
         stage_minor <= RST_REG;
         stage_flush <= RST_REG;
         stat_cfg    <= RST_REG;
      end else if (do_write && w_ok && w_lane0 && !w_refused) begin // [RULE_06]
         case (widx)
            IDX_ATTR:  stage_attr  <= w_byte & MASK_ATTR;
            IDX_MAJOR: stage_major <= w_byte;
            IDX_MINOR: stage_minor <= w_byte;
            IDX_FLUSH: stage_flush <= w_byte & MASK_FLUSH;
            IDX_STAT:  stat_cfg    <= w_byte & MASK_STAT;
            default: ;
         endcase
      end
   end

   // Lock bits only set; a newly set bit burns the staged field into OTP
   always_comb begin
      next_lock_hi = lock_hi;
      if (do_write && w_lane0 && widx == IDX_LOCK_HI && aw_addr[1:0] == 2'h0) begin
         next_lock_hi = lock_hi | w_byte;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_lo   <= RST_REG;
         lock_hi   <= RST_REG;
         otp_attr  <= RST_REG;
         otp_major <= RST_REG;
         otp_minor <= RST_REG;
         otp_flush <= RST_REG;
      end else begin
         if (do_write && w_lane0 && widx == IDX_LOCK_LO && aw_addr[1:0] == 2'h0) begin
            lock_lo <= lock_lo | w_byte; // [RULE_08]
         end
         lock_hi <= next_lock_hi; // [RULE_09]
         // Unwritten parts of a field burn as zeros
         if (next_lock_hi[LK_ATTR] && !lock_hi[LK_ATTR]) begin // [RULE_10]
            otp_attr <= stage_attr;
         end
         if (next_lock_hi[LK_RELEASE] && !lock_hi[LK_RELEASE]) begin
            otp_major <= stage_major;
            otp_minor <= stage_minor;
         end
         if (next_lock_hi[LK_FLUSH] && !lock_hi[LK_FLUSH]) begin
            otp_flush <= stage_flush;
         end
      end
   end

   // Effective values: OTP when locked, built-in default otherwise
   assign eff_attr  = lock_hi[LK_ATTR] ? otp_attr : usb_attr_s'(DEF_ATTR);  // [RULE_07] [RULE_15]
   assign eff_flush = lock_hi[LK_FLUSH] ? otp_flush : DEF_FLUSH;           // [RULE_07] [RULE_15]

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         desc_bm_attributes <= RST_REG;
         power_mode_invalid <= 1'b0;
         release_major      <= DEF_MAJOR;
         release_minor      <= DEF_MINOR;
         field_lock_lo      <= RST_REG;
         field_lock_hi      <= RST_REG;
      end else begin
         desc_bm_attributes                <= RST_REG;
         desc_bm_attributes[DESC_ONE]      <= 1'b1;
         desc_bm_attributes[DESC_SELF_PWR] <= (eff_attr.power_mode != PWR_BUS) &&
                                              (eff_attr.power_mode != PWR_INVALID); // [RULE_03]
         desc_bm_attributes[DESC_WAKE]     <= eff_attr.wake_valid & eff_attr.wake_en; // [RULE_01] [RULE_02]
         power_mode_invalid                <= eff_attr.power_mode == PWR_INVALID;     // [RULE_03]
         release_major                     <= lock_hi[LK_RELEASE] ? otp_major : DEF_MAJOR; // [RULE_07]
         release_minor                     <= lock_hi[LK_RELEASE] ? otp_minor : DEF_MINOR; // [RULE_15]
         field_lock_lo                     <= lock_lo; // [RULE_08]
         field_lock_hi                     <= lock_hi; // [RULE_09]
      end
   end

   // Read path: fields read back the OTP value once locked
   assign ridx = {2'h0, s_axi_araddr[ADDR_W-1:2]};

   always_comb begin
      rd_hit = s_axi_araddr[1:0] == 2'h0;
      case (ridx)
         IDX_ATTR:    rd_val = lock_hi[LK_ATTR] ? otp_attr : stage_attr;
         IDX_MAJOR:   rd_val = lock_hi[LK_RELEASE] ? otp_major : stage_major;
         IDX_MINOR:   rd_val = lock_hi[LK_RELEASE] ? otp_minor : stage_minor;
         IDX_FLUSH:   rd_val = lock_hi[LK_FLUSH] ? otp_flush : stage_flush;
         IDX_LOCK_LO: rd_val = lock_lo;
         IDX_LOCK_HI: rd_val = lock_hi;
         IDX_STAT:    rd_val = stat_cfg;
         default: begin
            rd_val = RST_REG;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_arready <= 1'b1;
      end else begin
         // Ready is registered as the inverse of the next valid
         s_axi_arready <= ~(s_axi_arvalid & s_axi_arready) & (s_axi_rready | ~s_axi_rvalid);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_hit ? rd_val : RST_REG};
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   fifo_flush_ctrl u_flush (
      .clock       (clock),
      .rstn        (rstn),
      .flush_cfg   (eff_flush),
      .port_opened (port_opened),
      .port_closed (port_closed),
      .rx_flush    (rx_fifo_flush),
      .tx_flush    (tx_fifo_flush)
   );

   stat_pin_drive u_stat (
      .clock     (clock),
      .rstn      (rstn),
      .cfg       (stat_cfg),
      .usb_state (usb_state),
      .pin_out   (suspend_indicator_pin),
      .pin_oe    (suspend_indicator_pin_oe)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   wake_shown_a: assert property (lock_hi[LK_ATTR] && otp_attr.wake_valid
                                  |=> desc_bm_attributes[DESC_WAKE] == $past(otp_attr.wake_en)) // [RULE_01]
      else $error("wakeup bit not advertised");
   wake_hidden_a: assert property (!(lock_hi[LK_ATTR] && otp_attr.wake_valid)
                                   |=> !desc_bm_attributes[DESC_WAKE]) // [RULE_02]
      else $error("wakeup advertised without valid");
   power_mode_a: assert property (lock_hi[LK_ATTR] && otp_attr.power_mode inside {2'h1, 2'h2}
                                  |=> desc_bm_attributes[DESC_SELF_PWR] && !power_mode_invalid) // [RULE_03]
      else $error("self powered not reported");
   locked_field_a: assert property (do_write && w_lane0 && widx == IDX_ATTR && lock_hi[LK_ATTR]
                                    |=> $stable(stage_attr) && s_axi_bresp == RESP_SLVERR) // [RULE_06]
      else $error("locked field accepted a write");
   lock_sticky_a: assert property ((lock_hi & $past(lock_hi)) == $past(lock_hi)) // [RULE_06]
      else $error("lock bit cleared");
   otp_used_a: assert property (lock_hi[LK_RELEASE] ##1 lock_hi[LK_RELEASE]
                                |-> release_major == $past(otp_major)) // [RULE_07]
      else $error("locked release not taken from OTP");
   default_used_a: assert property (!lock_hi[LK_RELEASE] |=> release_minor == DEF_MINOR) // [RULE_15]
      else $error("unlocked release not default");
   lock_map_a: assert property ($rose(lock_hi[LK_FLUSH]) |-> otp_flush == $past(stage_flush) ##1
                                field_lock_hi[LK_FLUSH]) // [RULE_09]
      else $error("flush lock did not burn field");
   lock_lo_map_a: assert property (1'b1 |=> field_lock_lo == $past(lock_lo)) // [RULE_08]
      else $error("low lock byte not reported");
   lock_lo_keep_a: assert property ((lock_lo & $past(lock_lo)) == $past(lock_lo)) // [RULE_06]
      else $error("low lock bit cleared");
   aw_ready_a: assert property (s_axi_awready == (!aw_held && !s_axi_bvalid))
      else $error("write address ready out of step");
   w_ready_a: assert property (s_axi_wready == (!w_held && !s_axi_bvalid))
      else $error("write data ready out of step");
   ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready out of step");
   burn_attr_c: cover property ($rose(lock_hi[LK_ATTR]) ##1 desc_bm_attributes[DESC_WAKE]);
   refuse_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // otp_usb_config_lock_bank

// *** design/otp_cfg_pkg.sv ***
// Constants, field layouts and carrier types of the OTP configuration bank
package otp_cfg_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_ATTR      = 8'h17;
   localparam logic [7:0]  IDX_MAJOR     = 8'h18;
   localparam logic [7:0]  IDX_MINOR     = 8'h19;
   localparam logic [7:0]  IDX_FLUSH     = 8'h1a;
   localparam logic [7:0]  IDX_LOCK_LO   = 8'h1b;
   localparam logic [7:0]  IDX_LOCK_HI   = 8'h1c;
   localparam logic [7:0]  IDX_STAT      = 8'h1f;
   // Values after reset and built-in defaults of unlocked fields
   localparam logic [7:0]  RST_REG       = 8'h00;
   localparam logic [7:0]  DEF_ATTR      = 8'h00;
   localparam logic [7:0]  DEF_MAJOR     = 8'h00;
   localparam logic [7:0]  DEF_MINOR     = 8'h00;
   localparam logic [7:0]  DEF_FLUSH     = 8'h00;
   // Writable bits; reserved bits read as zero
   localparam logic [7:0]  MASK_ATTR     = 8'h0f;
   localparam logic [7:0]  MASK_FLUSH    = 8'h1e;
   localparam logic [7:0]  MASK_STAT     = 8'h1f;
   // Attribute and descriptor bit positions
   localparam int          ATTR_WAKE_EN  = 3;
   localparam int          ATTR_WAKE_VLD = 2;
   localparam int          DESC_WAKE     = 5;
   localparam int          DESC_SELF_PWR = 6;
   localparam int          DESC_ONE      = 7;
   localparam logic [1:0]  PWR_BUS       = 2'h0;
   localparam logic [1:0]  PWR_INVALID   = 2'h3;
   // Flush control bit positions
   localparam int          FL_RX_CLOSE   = 4;
   localparam int          FL_RX_OPEN    = 3;
   localparam int          FL_TX_CLOSE   = 2;
   localparam int          FL_TX_OPEN    = 1;
   // Lock bit positions, high byte
   localparam int          LK_MAKER_TXT_B = 7;
   localparam int          LK_MAKER_TXT_A = 6;
   localparam int          LK_FLUSH      = 5;
   localparam int          LK_RELEASE    = 4;
   localparam int          LK_ATTR       = 3;
   localparam int          LK_MAX_POWER  = 2;
   localparam int          LK_PRODUCT    = 1;
   localparam int          LK_MAKER      = 0;
   // Lock bit positions, low byte
   localparam int          LK_LANGUAGE   = 7;
   localparam int          LK_PIN3       = 6;
   localparam int          LK_PIN0       = 3;
   localparam int          LK_SERIAL_TXT = 2;
   localparam int          LK_PROD_TXT_B = 1;
   localparam int          LK_PROD_TXT_A = 0;
   // Status pin select and drive codes
   localparam logic [2:0]  SEL_SUSP_RST  = 3'h0;
   localparam logic [2:0]  SEL_SUSP      = 3'h1;
   localparam logic [2:0]  SEL_LOW_POWER_STATE   = 3'h2;
   localparam logic [2:0]  SEL_RST       = 3'h3;
   localparam logic [2:0]  SEL_SUSP_RST2 = 3'h4;
   localparam logic [2:0]  SEL_N_SUSP    = 3'h5;
   localparam logic [2:0]  SEL_N_LOW_POWER_STATE = 3'h6;
   localparam logic [2:0]  SEL_N_RST     = 3'h7;
   localparam logic [1:0]  DRV_OPEN_DRAIN = 2'h1;
   localparam logic [1:0]  DRV_PUSH_PULL = 2'h2;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [3:0] rsv;
      logic       wake_en;
      logic       wake_valid;
      logic [1:0] power_mode;
   } usb_attr_s;

   typedef struct packed {
      logic [2:0] rsv;
      logic [2:0] sel;
      logic [1:0] ctrl;
   } stat_cfg_s;

   typedef struct packed {
      logic suspend;
      logic low_power;
      logic bus_reset;
   } usb_state_s;
endpackage

// *** design/fifo_flush_ctrl.sv ***
// Automatic FIFO flush pulses on serial port open and close events
`timescale 1ns/1ns
module fifo_flush_ctrl (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic [7:0] flush_cfg,
   input  wire logic       port_opened,
   input  wire logic       port_closed,
   output logic            rx_flush,
   output logic            tx_flush
);
   import otp_cfg_pkg::*;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_flush <= 1'b0;
         tx_flush <= 1'b0;
      end else begin
         rx_flush <= (port_closed & flush_cfg[FL_RX_CLOSE]) | (port_opened & flush_cfg[FL_RX_OPEN]); // [RULE_04]
         tx_flush <= (port_closed & flush_cfg[FL_TX_CLOSE]) | (port_opened & flush_cfg[FL_TX_OPEN]); // [RULE_05]
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   rx_close_a: assert property (port_closed && flush_cfg[FL_RX_CLOSE] |=> rx_flush) // [RULE_04]
      else $error("rx flush missing on close");
   rx_quiet_a: assert property (!(port_opened || port_closed) |=> !rx_flush && !tx_flush) // [RULE_04]
      else $error("flush without port event");
   tx_open_a: assert property (port_opened && flush_cfg[FL_TX_OPEN] |=> tx_flush) // [RULE_05]
      else $error("tx flush missing on open");
   tx_skip_a: assert property (port_closed && !port_opened && !flush_cfg[FL_TX_CLOSE] |=> !tx_flush) // [RULE_05]
      else $error("tx flush on close while disabled");
   flush_seen_c: cover property (port_closed ##1 rx_flush);
endmodule // fifo_flush_ctrl

// *** design/stat_pin_drive.sv ***
// Suspend indicator pin level and driver type
`timescale 1ns/1ns
module stat_pin_drive (
   input  wire logic                   clock,
   input  wire logic                   rstn,
   input  wire otp_cfg_pkg::stat_cfg_s cfg,
   input  wire otp_cfg_pkg::usb_state_s usb_state,
   output logic                        pin_out,
   output logic                        pin_oe
);
   import otp_cfg_pkg::*;

   logic cond;
   logic level;

   always_comb begin
      case (cfg.sel)
         SEL_SUSP_RST, SEL_SUSP_RST2: cond = usb_state.suspend | usb_state.bus_reset; // [RULE_11]
         SEL_SUSP, SEL_N_SUSP:        cond = usb_state.suspend;
         SEL_LOW_POWER_STATE, SEL_N_LOW_POWER_STATE:  cond = usb_state.low_power;
         SEL_RST, SEL_N_RST:          cond = usb_state.bus_reset;
         default:                     cond = 1'b0;
      endcase
      // Upper three codes are active low
      level = (cfg.sel >= SEL_N_SUSP) ? ~cond : cond; // [RULE_12]
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         case (cfg.ctrl)
            DRV_OPEN_DRAIN: begin // [RULE_13]
               pin_out <= 1'b0;
               pin_oe  <= ~level;
            end
            DRV_PUSH_PULL: begin
               pin_out <= level;
               pin_oe  <= 1'b1;
            end
            default: begin
               // Invalid drive codes leave the pin undriven
               pin_out <= 1'b0;
               pin_oe  <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   open_drain_a: assert property (cfg.ctrl == DRV_OPEN_DRAIN |=> !pin_out) // [RULE_13]
      else $error("open drain pin driven high");
   bad_ctrl_a: assert property (cfg.ctrl == 2'h0 || cfg.ctrl == 2'h3 |=> !pin_oe) // [RULE_13]
      else $error("invalid drive code drives pin");
   susp_high_a: assert property (cfg.ctrl == DRV_PUSH_PULL && cfg.sel == SEL_SUSP
                                 |=> pin_out == $past(usb_state.suspend)) // [RULE_11]
      else $error("suspend select level wrong");
   rst_low_a: assert property (cfg.ctrl == DRV_PUSH_PULL && cfg.sel == SEL_N_RST
                               |=> pin_out == !$past(usb_state.bus_reset)) // [RULE_12]
      else $error("inverted reset select level wrong");
   od_susp_c: cover property (cfg.ctrl == DRV_OPEN_DRAIN && usb_state.suspend ##1 pin_oe);
endmodule // stat_pin_drive

// *** bench/usb_side_model.sv ***
// Serial port events and USB bus state facing the flush and status outputs
`timescale 1ns/1ns
module usb_side_model (
   input  wire logic                   clock,
   input  wire logic                   rx_fifo_flush,
   input  wire logic                   tx_fifo_flush,
   output logic                        port_opened,
   output logic                        port_closed,
   output otp_cfg_pkg::usb_state_s     usb_state
);
   import otp_cfg_pkg::*;
   int rx_cnt = 0;
   int tx_cnt = 0;
   initial begin
      port_opened = 1'b0;
      port_closed = 1'b0;
      usb_state   = '0;
   end
   // Counts flush pulses seen by the FIFOs
   always @(posedge clock) begin
      if (rx_fifo_flush === 1'b1) rx_cnt++;
      if (tx_fifo_flush === 1'b1) tx_cnt++;
   end
   // New bus state, applied right after an edge
   task automatic set_state(input usb_state_s s);
      @(posedge clock);
      usb_state <= s;
   endtask
   // One-cycle open or close event
   task automatic port_event(input logic open);
      @(posedge clock);
      if (open) port_opened <= 1'b1;
      else port_closed <= 1'b1;
      @(posedge clock);
      port_opened <= 1'b0;
      port_closed <= 1'b0;
   endtask
endmodule // usb_side_model

// *** bench/tb_top.sv ***
// Register-level bench of the OTP configuration bank
`timescale 1ns/1ns
module tb_top;
   import otp_cfg_pkg::*;
   logic clock = 0, rstn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, opened, closed, rxf, txf, pin, pin_oe, pinv;
   logic [1:0] bresp, rresp;
   logic [7:0] desc, rmaj, rmin, lklo, lkhi;
   usb_state_s ust;
   int failures = 0, tests_run = 0;
   always #5 clock = ~clock;
   otp_usb_config_lock_bank DUT (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_opened(opened),
      .port_closed(closed), .usb_state(ust), .desc_bm_attributes(desc), .power_mode_invalid(pinv),
      .release_major(rmaj), .release_minor(rmin), .field_lock_lo(lklo), .field_lock_hi(lkhi),
      .rx_fifo_flush(rxf), .tx_fifo_flush(txf), .suspend_indicator_pin(pin), .suspend_indicator_pin_oe(pin_oe));
   usb_side_model PM (.clock(clock), .rx_fifo_flush(rxf), .tx_fifo_flush(txf), .port_opened(opened),
      .port_closed(closed), .usb_state(ust));
   task automatic finish_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang(input int n);
      if (n >= 40) begin
         failures++;
         $display("BAD %0t handshake timeout", $time);
         finish_test();
      end
   endtask
   // Write one byte; reserved bits are always sent as zero by callers
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic ad, wd;
      @(posedge clock);
      n = 0; ad = 0; wd = 0;
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(ad && wd && bvalid === 1'b1) && n < 40) begin
         @(posedge clock);
         n++;
         if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
         if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 0; end
      end
      hang(n);
      bready <= 0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      @(posedge clock);
      n = 0;
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin @(posedge clock); n++; if (arready === 1'b1) arvalid <= 0; end while (rvalid !== 1'b1 && n < 40);
      hang(n);
      rready <= 0;
      chk(rresp, er);
      if (er == RESP_OKAY) chk(rdata, {24'h0, ed});
   endtask
   task automatic settle();
      repeat (3) @(posedge clock);
   endtask
   task automatic pin_chk(input logic [7:0] cfg, input logic [1:0] exp);
      wr(8'h7c, cfg, RESP_OKAY);
      settle();
      chk({pin, pin_oe}, exp);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1;
      settle();
      chk(desc, 8'h80);
      rd(8'h5c, 8'h00, RESP_OKAY);
      rd(8'h40, 8'h00, RESP_SLVERR);
      wr(8'h5c, 8'h0e, RESP_OKAY);
      settle();
      chk(desc, 8'h80);
      wr(8'h70, 8'h08, RESP_OKAY);
      settle();
      chk({desc, pinv}, 9'h1c0);
      wr(8'h5c, 8'h02, RESP_SLVERR);
      rd(8'h5c, 8'h0e, RESP_OKAY);
      wr(8'h5c - 8'h00 + 8'h00, 8'h00, RESP_SLVERR);
      wr(8'h60, 8'h12, RESP_OKAY);
      wr(8'h64, 8'h34, RESP_OKAY);
      wr(8'h70, 8'h10, RESP_OKAY);
      settle();
      chk({rmaj, rmin}, 16'h1234);
      wr(8'h68, 8'h12, RESP_OKAY);
      wr(8'h70, 8'h20, RESP_OKAY);
      rd(8'h70, 8'h38, RESP_OKAY);
      chk(lkhi, 8'h38);
      wr(8'h6c, 8'h84, RESP_OKAY);
      rd(8'h6c, 8'h84, RESP_OKAY);
      chk(lklo, 8'h84);
      PM.port_event(1);
      settle();
      chk({PM.rx_cnt[7:0], PM.tx_cnt[7:0]}, 16'h0001);
      PM.port_event(0);
      settle();
      chk({PM.rx_cnt[7:0], PM.tx_cnt[7:0]}, 16'h0101);
      PM.set_state(3'b100);
      pin_chk(8'h06, 2'b11);
      pin_chk(8'h16, 2'b01);
      pin_chk(8'h05, 2'b00);
      PM.set_state(3'b001);
      pin_chk(8'h12, 2'b11);
      pin_chk(8'h1d, 2'b01);
      PM.set_state(3'b010);
      pin_chk(8'h0a, 2'b11);
      pin_chk(8'h0d, 2'b01);
      pin_chk(8'h02, 2'b01);
      pin_chk(8'h1a, 2'b01);
      finish_test();
   end
endmodule // tb_top
